/* File: rtl/mbpf_arbiter.sv */
// memory bus arbiter: five core request buses, fixed priority per target,
// flash/otp wait states, peripheral bus bridge
// assumes memories answer combinationally in the cycle of their grant
// assumes each requester holds its request until its done pulse
// assumes wait counts are set by software and stay level during an access
// assumes a flash or otp owner keeps its target field while it waits
`timescale 1ns/1ps
`include "mbpf_params.svh"

// Operation
// - the program read bus has a 22-bit address and 32-bit data.
// - data read and write buses have 32-bit address and data each.
// - fetch, data read and data write may proceed together on distinct targets.
// - each target grants data write, program write, data read, program read, fetch in that order.
// - a data write and a program write never pass in the same cycle.
// - a program read and a fetch never pass in the same cycle.
// - flash page and random waits are never below one cycle.
// - the bridge puts core buses on one 16-bit address, 16/32-bit data bus.
// - the second peripheral frame accepts only 16-bit accesses.
// - the first peripheral frame accepts 16 and 32-bit accesses.
module mbpf_arbiter (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire mbpf_pkg::mbpf_req_type fetch_i,
  input wire mbpf_pkg::mbpf_req_type prog_rd_i,
  input wire mbpf_pkg::mbpf_req_type prog_wr_i,
  input wire mbpf_pkg::mbpf_req_type data_rd_i,
  input wire mbpf_pkg::mbpf_req_type data_wr_i,
  input wire logic [`MBPF_WAIT_W-1:0] page_wait_i,
  input wire logic [`MBPF_WAIT_W-1:0] rand_wait_i,
  input wire logic [`MBPF_WAIT_W-1:0] otp_wait_i,
  input wire logic [`MBPF_DATA_W-1:0] ram_rdata_i,
  input wire logic [`MBPF_DATA_W-1:0] flash_rdata_i,
  input wire logic [`MBPF_DATA_W-1:0] otp_rdata_i,
  input wire logic [`MBPF_DATA_W-1:0] peri_rdata_i,
  output logic [4:0] grant_o,
  output logic [4:0] done_o,
  output logic [`MBPF_DATA_W-1:0] fetch_rdata_o,
  output logic [`MBPF_DATA_W-1:0] prog_rdata_o,
  output logic [`MBPF_DATA_W-1:0] data_rdata_o,
  output logic peri_valid_o,
  output logic peri_write_o,
  output logic peri_wide_o,
  output logic [`MBPF_PERI_ADDR_W-1:0] peri_addr_o,
  output logic [`MBPF_DATA_W-1:0] peri_wdata_o,
  output logic peri_error_o
);

  // ---------------------------------------------------------------
  // request collection
  // ---------------------------------------------------------------
  // index 0 is highest priority: dwr, pwr, drd, prd, fetch
  mbpf_pkg::mbpf_req_type req_s [5];
  logic [4:0] is_write_s;
  logic [4:0] eligible_s;
  logic [4:0] grant_s;

  // one wait machine per target
  logic [4:0] busy_tgt_s [4];
  logic [`MBPF_WAIT_W-1:0] cnt_q [4];
  logic [`MBPF_WAIT_W-1:0] cnt_d [4];
  logic [2:0] own_q [4];
  logic [2:0] own_d [4];
  mbpf_pkg::mbpf_state_type st_q [4];
  mbpf_pkg::mbpf_state_type st_d [4];

  // read answers
  logic [`MBPF_DATA_W-1:0] fetch_rdata_d;
  logic [`MBPF_DATA_W-1:0] prog_rdata_d;
  logic [`MBPF_DATA_W-1:0] data_rdata_d;
  logic [4:0] done_d;
  logic [4:0] done_q;

  // peripheral bus next values
  logic peri_valid_d;
  logic peri_write_d;
  logic peri_wide_d;
  logic peri_error_d;
  logic [`MBPF_PERI_ADDR_W-1:0] peri_addr_d;
  logic [`MBPF_DATA_W-1:0] peri_wdata_d;

  // program bus carries only 22 address bits
  always_comb begin
    req_s[0] = data_wr_i;
    req_s[1] = prog_wr_i;
    req_s[1].addr = {{(`MBPF_DADDR_W-`MBPF_PADDR_W){1'b0}},
                     prog_wr_i.addr[`MBPF_PADDR_W-1:0]};
    req_s[2] = data_rd_i;
    req_s[3] = prog_rd_i;
    req_s[3].addr = {{(`MBPF_DADDR_W-`MBPF_PADDR_W){1'b0}},
                     prog_rd_i.addr[`MBPF_PADDR_W-1:0]};
    req_s[4] = fetch_i;
    req_s[4].addr = {{(`MBPF_DADDR_W-`MBPF_PADDR_W){1'b0}},
                     fetch_i.addr[`MBPF_PADDR_W-1:0]};
    is_write_s = 5'h03;
  end

  // data write blocks program write, program read blocks fetch
  always_comb begin
    eligible_s[0] = req_s[0].req;
    eligible_s[1] = req_s[1].req && !req_s[0].req;
    eligible_s[2] = req_s[2].req;
    eligible_s[3] = req_s[3].req;
    eligible_s[4] = req_s[4].req && !req_s[3].req;
  end

  // ---------------------------------------------------------------
  // per-target arbitration and wait counting
  // ---------------------------------------------------------------
  // one arbiter and wait machine for each of the four targets
  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_tgt
      logic [4:0] hit_s;
      logic [4:0] win_s;
      logic [`MBPF_WAIT_W-1:0] waits_s;
      // which eligible sources want this target
      always_comb begin
        for (int s = 0; s < 5; s++) begin
          hit_s[s] = eligible_s[s] &&
                     (req_s[s].target == `MBPF_TGT_W'(t));
        end
        // scan from the lowest priority so the highest hit lands last
        win_s = 5'h00;
        for (int s = 4; s >= 0; s--) begin
          if (hit_s[s]) begin
            win_s = 5'h01 << s;
          end
        end
      end
      // wait count, clamped to at least one for flash and otp
      // page or random picked by the data write address pair parity
      always_comb begin
        if (`MBPF_TGT_W'(t) == `MBPF_TGT_OTP) begin
          waits_s = otp_wait_i;
        end else if (req_s[0].addr[0] ^ req_s[0].addr[1]) begin
          waits_s = rand_wait_i;
        end else begin
          waits_s = page_wait_i;
        end
        if (waits_s < `MBPF_WAIT_MIN) begin
          waits_s = `MBPF_WAIT_MIN;
        end
      end
      // next state of the target's wait machine
      always_comb begin
        st_d[t] = st_q[t];
        cnt_d[t] = cnt_q[t];
        own_d[t] = own_q[t];
        busy_tgt_s[t] = 5'h00;
        case (st_q[t])
          mbpf_pkg::MBPF_IDLE: begin
            busy_tgt_s[t] = win_s;
            if ((win_s != 5'h00) &&
                ((`MBPF_TGT_W'(t) == `MBPF_TGT_FLASH) ||
                 (`MBPF_TGT_W'(t) == `MBPF_TGT_OTP))) begin
              // hold the winner for its wait count
              st_d[t] = mbpf_pkg::MBPF_WAIT;
              cnt_d[t] = waits_s;
              // remember which source owns the wait
              for (int s = 0; s < 5; s++) begin
                if (win_s[s]) begin
                  own_d[t] = 3'(s);
                end
              end
              busy_tgt_s[t] = 5'h00;
            end
          end
          mbpf_pkg::MBPF_WAIT: begin
            if (cnt_q[t] > `MBPF_WAIT_MIN) begin
              // count down the remaining wait cycles
              cnt_d[t] = cnt_q[t] - `MBPF_WAIT_W'(1);
            end else if (!req_s[own_q[t]].req) begin
              // owner withdrew: free the target, no access
              st_d[t] = mbpf_pkg::MBPF_IDLE;
            end else if (eligible_s[own_q[t]]) begin
              // last wait cycle; held while an exclusive pair blocks it
              st_d[t] = mbpf_pkg::MBPF_IDLE;
              busy_tgt_s[t] = 5'h01 << own_q[t];
            end
          end
          default: st_d[t] = mbpf_pkg::MBPF_IDLE;
        endcase
      end
      // registers of the wait machine
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          st_q[t] <= mbpf_pkg::MBPF_IDLE;
          cnt_q[t] <= '0;
          own_q[t] <= 3'h0;
        end else begin
          st_q[t] <= st_d[t];
          cnt_q[t] <= cnt_d[t];
          own_q[t] <= own_d[t];
        end
      end
    end
  endgenerate

  // grants: distinct targets pass together in one cycle
  assign grant_s = busy_tgt_s[0] | busy_tgt_s[1] |
                   busy_tgt_s[2] | busy_tgt_s[3];
  // grant pulses leave combinationally
  assign grant_o = grant_s;

  // ---------------------------------------------------------------
  // read data return
  // ---------------------------------------------------------------
  // route the winner's memory word back onto its read bus
  always_comb begin
    logic [`MBPF_DATA_W-1:0] rd;
    rd = '0;
    fetch_rdata_d = fetch_rdata_o;
    prog_rdata_d = prog_rdata_o;
    data_rdata_d = data_rdata_o;
    done_d = grant_s;
    for (int s = 0; s < 5; s++) begin
      if (grant_s[s]) begin
        case (req_s[s].target)
          `MBPF_TGT_FLASH: rd = flash_rdata_i;
          `MBPF_TGT_OTP: rd = otp_rdata_i;
          `MBPF_TGT_PERI: rd = peri_rdata_i;
          default: rd = ram_rdata_i;
        endcase
        // writes take no word back
        if (s == 2) begin
          data_rdata_d = rd;
        end else if (s == 3) begin
          prog_rdata_d = rd;
        end else if (s == 4) begin
          fetch_rdata_d = rd;
        end
      end
    end
  end

  // registered read answers, held until the next read
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_rdata_o <= '0;
      prog_rdata_o <= '0;
      data_rdata_o <= '0;
      done_q <= 5'h00;
    end else begin
      fetch_rdata_o <= fetch_rdata_d;
      prog_rdata_o <= prog_rdata_d;
      data_rdata_o <= data_rdata_d;
      done_q <= done_d;
    end
  end
  assign done_o = done_q;

  // ---------------------------------------------------------------
  // peripheral bus bridge
  // ---------------------------------------------------------------
  // drive the peripheral bus for the one winner on that target
  always_comb begin
    peri_valid_d = 1'b0;
    peri_write_d = 1'b0;
    peri_wide_d = 1'b0;
    peri_error_d = 1'b0;
    peri_addr_d = peri_addr_o;
    peri_wdata_d = peri_wdata_o;
    for (int s = 0; s < 5; s++) begin
      if (grant_s[s] && (req_s[s].target == `MBPF_TGT_PERI)) begin
        peri_addr_d = req_s[s].addr[`MBPF_PERI_ADDR_W-1:0];
        peri_write_d = is_write_s[s];
        peri_wdata_d = req_s[s].wdata;
        // a wide access to the second frame is refused
        if (req_s[s].wide &&
            req_s[s].addr[`MBPF_PERI_FRAME2_BIT]) begin
          peri_error_d = 1'b1;
        end else begin
          peri_valid_d = 1'b1;
          peri_wide_d = req_s[s].wide;
        end
      end
    end
  end

  // registered peripheral bus, strobes last one cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peri_valid_o <= 1'b0;
      peri_write_o <= 1'b0;
      peri_wide_o <= 1'b0;
      peri_error_o <= 1'b0;
      peri_addr_o <= '0;
      peri_wdata_o <= '0;
    end else begin
      peri_valid_o <= peri_valid_d;
      peri_write_o <= peri_write_d;
      peri_wide_o <= peri_wide_d;
      peri_error_o <= peri_error_d;
      peri_addr_o <= peri_addr_d;
      peri_wdata_o <= peri_wdata_d;
    end
  end

endmodule : mbpf_arbiter

/* File: rtl/mbpf_params.svh */
// constants for the memory bus arbiter with flash wait states
// assumes inclusion by the single design file and the package
`ifndef MBPF_PARAMS_SVH
`define MBPF_PARAMS_SVH
`define MBPF_PADDR_W 22
`define MBPF_DADDR_W 32
`define MBPF_DATA_W 32
`define MBPF_PERI_ADDR_W 16
`define MBPF_WAIT_W 4
`define MBPF_FLASH_PAGE_NS 36
`define MBPF_FLASH_RAND_NS 36
`define MBPF_OTP_NS 60
`define MBPF_CLK_NS 50
`define MBPF_WAIT_MIN 4'h1
`define MBPF_TGT_W 2
`define MBPF_TGT_RAM 2'h0
`define MBPF_TGT_FLASH 2'h1
`define MBPF_TGT_OTP 2'h2
`define MBPF_TGT_PERI 2'h3
`define MBPF_PERI_FRAME2_BIT 15
`endif

/* File: rtl/mbpf_pkg.sv */
// types for the memory bus arbiter with flash wait states
// assumes the params header sits beside it in rtl/
`include "mbpf_params.svh"
package mbpf_pkg;
  // request from one core bus
  typedef struct packed {
    logic req;
    logic [`MBPF_DADDR_W-1:0] addr;
    logic [`MBPF_DATA_W-1:0] wdata;
    logic [`MBPF_TGT_W-1:0] target;
    logic wide;
  } mbpf_req_type;
  // request sources in priority order, highest first
  typedef enum logic [2:0] {
    MBPF_SRC_DWR,
    MBPF_SRC_PWR,
    MBPF_SRC_DRD,
    MBPF_SRC_PRD,
    MBPF_SRC_FETCH,
    MBPF_SRC_NONE
  } mbpf_src_type;
  typedef enum {
    MBPF_IDLE,
    MBPF_WAIT
  } mbpf_state_type;
endpackage : mbpf_pkg

/* File: test/mbpf_arbiter_sva.sv */
// checker on the arbiter ports: priority, waits, peripheral frames
// assumes a bind onto mbpf_arbiter from the bench top file
`timescale 1ns/1ps
`include "mbpf_params.svh"
module mbpf_arbiter_sva (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire mbpf_pkg::mbpf_req_type prog_wr_i,
  input wire mbpf_pkg::mbpf_req_type data_rd_i,
  input wire mbpf_pkg::mbpf_req_type data_wr_i,
  input wire mbpf_pkg::mbpf_req_type prog_rd_i,
  input wire logic [`MBPF_WAIT_W-1:0] page_wait_i,
  input wire logic [`MBPF_WAIT_W-1:0] rand_wait_i,
  input wire logic [`MBPF_WAIT_W-1:0] otp_wait_i,
  input wire logic [4:0] grant_o,
  input wire logic [4:0] done_o,
  input wire logic peri_valid_o,
  input wire logic peri_write_o,
  input wire logic peri_error_o,
  input wire logic [`MBPF_PERI_ADDR_W-1:0] peri_addr_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // a data read to ram with no writer there
  logic rd_ram;
  assign rd_ram = data_rd_i.req && data_rd_i.target == `MBPF_TGT_RAM
    && !(data_wr_i.req && data_wr_i.target == `MBPF_TGT_RAM)
    && !(prog_wr_i.req && prog_wr_i.target == `MBPF_TGT_RAM);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_wr_excl: assert property (data_wr_i.req |-> !grant_o[1])
    else $error("program write granted beside data write");
  a_fetch_excl: assert property (prog_rd_i.req |-> !grant_o[4])
    else $error("fetch granted beside program read");
  a_done_follows: assert property (grant_o != 5'h00 |=>
    done_o == $past(grant_o)) else $error("done not after grant");
  a_ram_now: assert property (rd_ram |-> grant_o[2])
    else $error("ram read not granted at once");
  a_rd_over_prd: assert property (data_rd_i.req && prog_rd_i.req
    && data_rd_i.target == prog_rd_i.target |-> !grant_o[3])
    else $error("program read beat data read");
  a_frame2_err: assert property (grant_o[2]
    && data_rd_i.target == `MBPF_TGT_PERI && data_rd_i.wide
    && data_rd_i.addr[15] |=> peri_error_o && !peri_valid_o)
    else $error("wide frame two access not refused");
  a_frame1_wr: assert property (grant_o[0]
    && data_wr_i.target == `MBPF_TGT_PERI && !data_wr_i.addr[15]
    |=> peri_valid_o && peri_write_o
    && peri_addr_o == $past(data_wr_i.addr[15:0]))
    else $error("frame one write not passed");
  a_otp_wait: assert property ($rose(data_rd_i.req)
    && data_rd_i.target == `MBPF_TGT_OTP && otp_wait_i == 4'h5
    |-> !grant_o[2] [*5] ##1 grant_o[2]) else $error("otp wait wrong");
  a_flash_min: assert property ($rose(data_rd_i.req)
    && data_rd_i.target == `MBPF_TGT_FLASH && page_wait_i == 4'h0
    && rand_wait_i == 4'h0 |-> !grant_o[2] ##1 grant_o[2])
    else $error("flash wait below one");
  c_parallel: cover property (grant_o == 5'h05);
  c_error: cover property (peri_error_o);
  c_fetch: cover property (done_o[4]);
endmodule : mbpf_arbiter_sva

/* File: test/mbpf_mem_model.sv */
// far-side memories: a fixed read word for each target
// assumes the arbiter samples them in the grant cycle
`timescale 1ns/1ps
module mbpf_mem_model #(
  parameter logic [31:0] RAM_W = 32'h1234_5678,
  parameter logic [31:0] FL_W = 32'h9ABC_DEF0,
  parameter logic [31:0] OTP_W = 32'h0F1E_2D3C,
  parameter logic [31:0] PER_W = 32'h4B3C_2D1E
) (
  output logic [31:0] ram_o,
  output logic [31:0] fl_o,
  output logic [31:0] otp_o,
  output logic [31:0] per_o
);
  // combinational answers, no latency of their own
  assign ram_o = RAM_W;
  assign fl_o = FL_W;
  assign otp_o = OTP_W;
  assign per_o = PER_W;
endmodule : mbpf_mem_model

/* File: test/test_mbpf_arbiter.sv */
// self-checking bench for the memory bus arbiter
// assumes checker and memory model compile before it
`timescale 1ns/1ps
`include "mbpf_params.svh"
module test_mbpf_arbiter;
  localparam int FW0 = (`MBPF_FLASH_PAGE_NS + `MBPF_CLK_NS - 1)
    / `MBPF_CLK_NS - 1;
  localparam int FW = FW0 < 1 ? 1 : FW0;
  localparam int OW0 = (`MBPF_OTP_NS + `MBPF_CLK_NS - 1) / `MBPF_CLK_NS - 1;
  localparam int OW = OW0 < 1 ? 1 : OW0;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  mbpf_pkg::mbpf_req_type r [5];
  mbpf_pkg::mbpf_req_type data_wr_i, prog_wr_i, data_rd_i, prog_rd_i, fetch_i;
  logic [3:0] page_wait_i = 4'h1, rand_wait_i = 4'h1, otp_wait_i = 4'h1;
  logic [31:0] ram_rdata_i, flash_rdata_i, otp_rdata_i, peri_rdata_i;
  logic [4:0] grant_o, done_o;
  logic [31:0] fetch_rdata_o, prog_rdata_o, data_rdata_o, peri_wdata_o;
  logic peri_valid_o, peri_write_o, peri_wide_o, peri_error_o;
  logic [15:0] peri_addr_o;
  int mismatches = 0;
  int compares = 0;
  // request slots, index equals grant bit
  assign data_wr_i = r[0];
  assign prog_wr_i = r[1];
  assign data_rd_i = r[2];
  assign prog_rd_i = r[3];
  assign fetch_i = r[4];
  always #25 clock_i = ~clock_i;
  mbpf_arbiter dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .fetch_i(fetch_i),
    .prog_rd_i(prog_rd_i), .prog_wr_i(prog_wr_i), .data_rd_i(data_rd_i),
    .data_wr_i(data_wr_i), .page_wait_i(page_wait_i),
    .rand_wait_i(rand_wait_i), .otp_wait_i(otp_wait_i),
    .ram_rdata_i(ram_rdata_i), .flash_rdata_i(flash_rdata_i),
    .otp_rdata_i(otp_rdata_i), .peri_rdata_i(peri_rdata_i),
    .grant_o(grant_o), .done_o(done_o), .fetch_rdata_o(fetch_rdata_o),
    .prog_rdata_o(prog_rdata_o), .data_rdata_o(data_rdata_o),
    .peri_valid_o(peri_valid_o), .peri_write_o(peri_write_o),
    .peri_wide_o(peri_wide_o), .peri_addr_o(peri_addr_o),
    .peri_wdata_o(peri_wdata_o), .peri_error_o(peri_error_o));
  mbpf_mem_model mem (.ram_o(ram_rdata_i), .fl_o(flash_rdata_i),
    .otp_o(otp_rdata_i), .per_o(peri_rdata_i));
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic put(int k, logic [1:0] t, logic [31:0] a, logic w);
    r[k] = '{1'b1, a, 32'h5A00_0000 + 32'(k), t, w};
  endtask : put
  // data read to ram beside a wide frame one write
  task automatic t_parallel();
    @(negedge clock_i);
    put(2, `MBPF_TGT_RAM, 32'h0000_0100, 1'b1);
    put(0, `MBPF_TGT_PERI, 32'h0000_0044, 1'b1);
    #1 check("grant", 32'(grant_o), 32'h05);
    @(negedge clock_i);
    check("done", 32'(done_o), 32'h05);
    check("rdata", data_rdata_o, mem.RAM_W);
    check("peri", 32'({peri_valid_o, peri_write_o, peri_wide_o,
      peri_error_o, peri_addr_o}), 32'h000E_0044);
    check("pwdata", peri_wdata_o, 32'h5A00_0000);
    r[0].req = 1'b0;
    r[2].req = 1'b0;
  endtask : t_parallel
  // all five buses on ram at once, served one by one
  task automatic t_prio();
    @(negedge clock_i);
    for (int k = 0; k < 5; k++) begin
      put(k, `MBPF_TGT_RAM, 32'h0000_0200, 1'b1);
    end
    for (int k = 0; k < 5; k++) begin
      #1 check("order", 32'(grant_o), 32'(1 << k));
      @(negedge clock_i);
      check("odone", 32'(done_o), 32'(1 << k));
      r[k].req = 1'b0;
    end
    check("fetch", fetch_rdata_o, mem.RAM_W);
    check("prog", prog_rdata_o, mem.RAM_W);
  endtask : t_prio
  // one stalled read, counting cycles until done
  task automatic t_wait(logic [1:0] t, logic [3:0] w, logic [3:0] rw, int n,
    logic [31:0] d);
    int c;
    c = 1;
    @(negedge clock_i);
    page_wait_i = w;
    rand_wait_i = rw;
    otp_wait_i = w;
    put(2, t, 32'h0000_0300, 1'b1);
    @(negedge clock_i);
    while (done_o[2] !== 1'b1 && c < 20) begin
      @(negedge clock_i);
      c++;
    end
    check("wait", 32'(c), 32'(n + 1));
    check("wdata", data_rdata_o, d);
    r[2].req = 1'b0;
  endtask : t_wait
  // data read on the peripheral bus, frame picked by address
  task automatic t_peri(logic [31:0] a, logic w, logic e);
    @(negedge clock_i);
    put(2, `MBPF_TGT_PERI, a, w);
    @(negedge clock_i);
    check("pflags", 32'({peri_valid_o, peri_write_o, peri_error_o,
      done_o[2]}), 32'({~e, 1'b0, e, 1'b1}));
    if (!e) check("pdata", data_rdata_o, mem.PER_W);
    r[2].req = 1'b0;
  endtask : t_peri
  task automatic test_done();
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    foreach (r[i]) r[i] = '0;
    repeat (12) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_parallel();
    t_prio();
    t_wait(`MBPF_TGT_OTP, 4'h5, 4'h5, 5, mem.OTP_W);
    t_wait(`MBPF_TGT_FLASH, 4'h3, 4'h3, 3, mem.FL_W);
    t_wait(`MBPF_TGT_FLASH, 4'h0, 4'h0, 1, mem.FL_W);
    t_wait(`MBPF_TGT_FLASH, 4'(FW), 4'(FW), FW, mem.FL_W);
    t_wait(`MBPF_TGT_OTP, 4'(OW), 4'(OW), OW, mem.OTP_W);
    t_wait(`MBPF_TGT_FLASH, 4'h2, 4'h4, 2, mem.FL_W);
    r[0].addr = 32'h0000_0001; // odd address pair selects random waits
    t_wait(`MBPF_TGT_FLASH, 4'h2, 4'h4, 4, mem.FL_W);
    t_peri(32'h0000_8010, 1'b1, 1'b1);
    t_peri(32'h0000_8012, 1'b0, 1'b0);
    t_peri(32'h0000_0010, 1'b1, 1'b0);
    test_done();
  end
  // watchdog against a hang
  initial begin
    repeat (2000) @(posedge clock_i);
    mismatches++;
    test_done();
  end
endmodule : test_mbpf_arbiter
bind mbpf_arbiter mbpf_arbiter_sva chk (.*);
